// File: src/plsl_top.sv
// plsl_top: clock output, indicators, reset, shared pin and straps
// assumes one 100 MHz clock, straps and status synchronous to it
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "plsl_map.svh"
module plsl_top
    import plsl_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = `PLSL_BLINK_CYC,
    parameter bit          LED_ACTIVE_LOW    = 1'b1
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             irq,
    // reference and clock output
    input  wire logic        ref_clock_input,
    output logic             crystal_drive_output,
    output logic             system_clock_output,
    // link status from the core
    input  wire logic        link_good,
    input  wire logic        speed_100,
    input  wire logic        tx_active,
    input  wire logic        rx_active,
    input  wire logic        collision,
    input  wire logic        full_duplex,
    // indicators
    output logic             link_indicator_o,
    output logic             link_indicator_oe,
    output logic             speed_indicator_o,
    output logic             speed_indicator_oe,
    output logic             activity_collision_indicator_o,
    output logic             activity_collision_indicator_oe,
    // shared power-down / interrupt pin
    input  wire logic        powerdown_irq_pin_i,
    output logic             powerdown_irq_pin_o,
    output logic             powerdown_irq_pin_oe,
    output logic             power_down,
    // straps
    input  wire logic        rmii_strap,
    input  wire logic        phy_addr_strap_bit0,
    input  wire logic [3:0]  phy_addr_strap_upper,
    output logic      [4:0]  phy_addr_pull_up,
    output logic             straps_released,
    output logic             mii_isolate,
    output logic             rmii_mode
);
    plsl_state_t          state_q;
    plsl_led_mode_t       led_mode_q;
    logic                 dup_sel_q;
    logic                 irq_pin_en_q;
    logic [4:0]           phy_addr_q;
    logic [`PLSL_IRQ_W-1:0] irq_stat_q;
    logic [`PLSL_IRQ_W-1:0] irq_mask_q;
    logic [`PLSL_IRQ_W-1:0] ev;
    logic [3:0]           prev_q;
    logic                 col_q;
    logic [1:0]           div_q;
    logic [1:0]           half;
    logic                 running;
    logic                 rd_irq;
    logic [15:0]          rdata_d;
    logic [7:0]           ref_mhz;
    logic                 link_indicator;
    logic                 speed_indicator;
    logic                 led_actcol;

    assign running = (state_q == PLSL_ST_RUN);
    assign rd_irq  = reg_rd && (reg_addr == `PLSL_OFS_IRQ_STAT);

    // ==========================================================
    // strap sampling after reset release
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= PLSL_ST_SAMPLE;
        end else begin
            case (state_q)
                PLSL_ST_SAMPLE: state_q <= PLSL_ST_RUN;
                PLSL_ST_RUN:    state_q <= PLSL_ST_RUN;
                default:        state_q <= PLSL_ST_SAMPLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rmii_mode   <= 1'b0;
            mii_isolate <= 1'b0;
        end else if (state_q == PLSL_ST_SAMPLE) begin
            rmii_mode   <= rmii_strap;
            mii_isolate <= ({phy_addr_strap_upper, phy_addr_strap_bit0}
                            == `PLSL_ADDR_ZERO);
        end
    end

    // pull direction of the undriven address straps
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phy_addr_pull_up <= `PLSL_ADDR_PULL;
            straps_released  <= 1'b0;
        end else begin
            phy_addr_pull_up <= `PLSL_ADDR_PULL;
            straps_released  <= running;
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            led_mode_q   <= plsl_led_mode_t'(`PLSL_RST_MODE);
            dup_sel_q    <= 1'b0;
            irq_pin_en_q <= 1'b0;
        end else if (reg_wr && reg_addr == `PLSL_OFS_CTRL) begin
            led_mode_q   <= plsl_led_mode_t'(reg_wdata[`PLSL_CTRL_MODE_HI:`PLSL_CTRL_MODE_LO]);
            dup_sel_q    <= reg_wdata[`PLSL_CTRL_DUPSEL];
            irq_pin_en_q <= reg_wdata[`PLSL_CTRL_IRQPIN];
        end
    end

    // ==========================================================
    // phy address: strapped, then writable without isolate effect
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phy_addr_q <= `PLSL_ADDR_ZERO;
        end else if (state_q == PLSL_ST_SAMPLE) begin
            phy_addr_q <= {phy_addr_strap_upper, phy_addr_strap_bit0};
        end else if (reg_wr && reg_addr == `PLSL_OFS_PHY_CONTROL_REGISTER) begin
            phy_addr_q <= reg_wdata[`PLSL_PHY_ADDR_HI:0];
        end
    end

    // ==========================================================
    // interrupt events, sticky status, mask
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 4'h0;
            col_q  <= 1'b0;
        end else begin
            prev_q <= {full_duplex, 1'b0, speed_100, link_good};
            col_q  <= collision;
        end
    end

    always_comb begin
        ev = '0;
        if (running) begin
            ev[`PLSL_EV_LINK]   = link_good ^ prev_q[0];
            ev[`PLSL_EV_SPEED]  = speed_100 ^ prev_q[1];
            ev[`PLSL_EV_COL]    = collision & ~col_q;
            ev[`PLSL_EV_DUPLEX] = full_duplex ^ prev_q[3];
        end
    end

    // set wins over the read clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | ev;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_q <= `PLSL_RST_MASK;
        end else if (reg_wr && reg_addr == `PLSL_OFS_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[`PLSL_IRQ_W-1:0];
        end
    end

    // irq follows the masked status in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((rd_irq ? '0 : irq_stat_q) | ev) & irq_mask_q);
        end
    end

    // ==========================================================
    // shared pin: power-down input or open-drain interrupt
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            powerdown_irq_pin_o  <= 1'b0;
            powerdown_irq_pin_oe <= 1'b0;
            power_down           <= 1'b0;
        end else begin
            powerdown_irq_pin_o  <= 1'b0;
            powerdown_irq_pin_oe <= irq_pin_en_q &
                                    (|(((rd_irq ? '0 : irq_stat_q) | ev) & irq_mask_q));
            power_down           <= ~irq_pin_en_q & ~powerdown_irq_pin_i;
        end
    end

    // ==========================================================
    // reference and system clock output
    always_comb begin
        if (rmii_mode) begin
            half    = 2'(`PLSL_HALF_RMII);
            ref_mhz = 8'(`PLSL_REF_RMII_MHZ);
        end else begin
            half    = 2'(`PLSL_HALF_MII);
            ref_mhz = 8'(`PLSL_REF_MII_MHZ);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q               <= 2'h0;
            system_clock_output <= 1'b0;
        end else if (!running) begin
            div_q               <= 2'h0;
            system_clock_output <= 1'b0;
        end else if (div_q >= half - 2'h1) begin
            div_q               <= 2'h0;
            system_clock_output <= ~system_clock_output;
        end else begin
            div_q               <= div_q + 2'h1;
        end
    end

    // crystal drive inverts the reference in MII mode, held low in RMII mode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            crystal_drive_output <= 1'b0;
        end else begin
            crystal_drive_output <= ~ref_clock_input & ~rmii_mode;
        end
    end

    // ==========================================================
    // indicators
    plsl_led_drive #(
        .BLINK_HALF_CYCLES (BLINK_HALF_CYCLES),
        .ACTIVE_LOW        (LED_ACTIVE_LOW)
    ) u_led (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .led_mode     (led_mode_q),
        .dup_sel      (dup_sel_q),
        .link_good    (link_good),
        .speed_100    (speed_100),
        .tx_active    (tx_active),
        .rx_active    (rx_active),
        .collision    (collision),
        .full_duplex  (full_duplex),
        .link_led_q   (link_indicator),
        .speed_led_q  (speed_indicator),
        .actcol_led_q (led_actcol)
    );

    // indicator pins stay released while straps are sampled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link_indicator_o                <= 1'b0;
            link_indicator_oe               <= 1'b0;
            speed_indicator_o               <= 1'b0;
            speed_indicator_oe              <= 1'b0;
            activity_collision_indicator_o  <= 1'b0;
            activity_collision_indicator_oe <= 1'b0;
        end else begin
            link_indicator_o                <= link_indicator;
            link_indicator_oe               <= running;
            speed_indicator_o               <= speed_indicator;
            speed_indicator_oe              <= running;
            activity_collision_indicator_o  <= led_actcol;
            activity_collision_indicator_oe <= running;
        end
    end

    // ==========================================================
    // read data, one cycle after the strobe
    always_comb begin
        rdata_d = 16'h0000;
        case (reg_addr)
            `PLSL_OFS_CTRL: begin
                rdata_d[`PLSL_CTRL_MODE_HI:`PLSL_CTRL_MODE_LO] = led_mode_q;
                rdata_d[`PLSL_CTRL_DUPSEL] = dup_sel_q;
                rdata_d[`PLSL_CTRL_IRQPIN] = irq_pin_en_q;
            end
            `PLSL_OFS_PHY_CONTROL_REGISTER: begin
                rdata_d[`PLSL_PHY_ADDR_HI:0] = phy_addr_q;
                rdata_d[`PLSL_PHY_ISO]       = mii_isolate;
            end
            `PLSL_OFS_STAT: begin
                rdata_d[`PLSL_ST_RMII]  = rmii_mode;
                rdata_d[`PLSL_ST_PDOWN] = power_down;
                rdata_d[`PLSL_ST_ISO]   = mii_isolate;
                rdata_d[`PLSL_ST_LINK]  = link_good;
                rdata_d[`PLSL_ST_SPD]   = speed_100;
                rdata_d[`PLSL_ST_REF_HI:`PLSL_ST_REF_LO] = ref_mhz;
            end
            `PLSL_OFS_IRQ_STAT: begin
                rdata_d[`PLSL_IRQ_W-1:0] = irq_stat_q;
            end
            `PLSL_OFS_IRQ_MASK: begin
                rdata_d[`PLSL_IRQ_W-1:0] = irq_mask_q;
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// File: src/plsl_map.svh
// plsl_map.svh: offsets, fields, reset values and timing counts
// assumes a 100 MHz clk_sys and the plain register port of plsl_top
// ==========================================================
`ifndef PLSL_MAP_SVH
`define PLSL_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define PLSL_OFS_CTRL       8'h00
`define PLSL_OFS_PHY_CONTROL_REGISTER    8'h04
`define PLSL_OFS_STAT       8'h08
`define PLSL_OFS_IRQ_STAT   8'h0c
`define PLSL_OFS_IRQ_MASK   8'h10

// ==========================================================
// fields
`define PLSL_CTRL_MODE_LO   0
`define PLSL_CTRL_MODE_HI   1
`define PLSL_CTRL_DUPSEL    2
`define PLSL_CTRL_IRQPIN    3
`define PLSL_PHY_ADDR_HI    4
`define PLSL_PHY_ISO        5
`define PLSL_ST_RMII        0
`define PLSL_ST_PDOWN       1
`define PLSL_ST_ISO         2
`define PLSL_ST_LINK        3
`define PLSL_ST_SPD         4
`define PLSL_ST_REF_LO      8
`define PLSL_ST_REF_HI      15
`define PLSL_IRQ_W          4
`define PLSL_EV_LINK        0
`define PLSL_EV_SPEED       1
`define PLSL_EV_COL         2
`define PLSL_EV_DUPLEX      3

// ==========================================================
// reset values
`define PLSL_RST_MODE       2'h1
`define PLSL_RST_MASK       4'h0
`define PLSL_ADDR_ZERO      5'h00
`define PLSL_ADDR_PULL      5'h01

// ==========================================================
// timing
`define PLSL_CLK_MHZ        100
`define PLSL_REF_RMII_MHZ   50
`define PLSL_REF_MII_MHZ    25
`define PLSL_RST_MIN_NS     1000
`define PLSL_CLK_NS         10
`define PLSL_RST_MIN_CYC    ((`PLSL_RST_MIN_NS + `PLSL_CLK_NS - 1) / `PLSL_CLK_NS)
`define PLSL_HALF_RMII      (`PLSL_CLK_MHZ / (2 * `PLSL_REF_RMII_MHZ))
`define PLSL_HALF_MII       (`PLSL_CLK_MHZ / (2 * `PLSL_REF_MII_MHZ))
`define PLSL_BLINK_NS       50000000
`define PLSL_BLINK_CYC      (`PLSL_BLINK_NS / `PLSL_CLK_NS)

`endif

// File: src/plsl_pkg.sv
// plsl_pkg: types shared by the sideband logic
// assumes nothing beyond the map header
package plsl_pkg;
    typedef enum logic [1:0] {
        PLSL_MODE_0 = 2'b00,
        PLSL_MODE_1 = 2'b01,
        PLSL_MODE_2 = 2'b10,
        PLSL_MODE_3 = 2'b11
    } plsl_led_mode_t;

    typedef enum logic [1:0] {
        PLSL_ST_SAMPLE = 2'b00,
        PLSL_ST_RUN    = 2'b01
    } plsl_state_t;
endpackage

// File: src/plsl_led_drive.sv
// plsl_led_drive: three status indicators with mode select and blink
// assumes status inputs synchronous to clk_sys
`timescale 1ns/10ps
`include "plsl_map.svh"
module plsl_led_drive
    import plsl_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = `PLSL_BLINK_CYC,
    parameter bit          ACTIVE_LOW        = 1'b1
) (
    // clock and reset
    input  wire logic           clk_sys,
    input  wire logic           reset_n,
    // control
    input  wire plsl_led_mode_t led_mode,
    input  wire logic           dup_sel,
    // status
    input  wire logic           link_good,
    input  wire logic           speed_100,
    input  wire logic           tx_active,
    input  wire logic           rx_active,
    input  wire logic           collision,
    input  wire logic           full_duplex,
    // indicators, pin levels
    output logic                link_led_q,
    output logic                speed_led_q,
    output logic                actcol_led_q
);
    logic [31:0] blink_cnt_q;
    logic        blink_ph_q;
    logic        active;
    logic        link_on;
    logic        actcol_on;

    assign active = tx_active | rx_active;

    // ==========================================================
    // blink phase
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            blink_cnt_q <= 32'h0;
            blink_ph_q  <= 1'b0;
        end else if (blink_cnt_q >= BLINK_HALF_CYCLES - 1) begin
            blink_cnt_q <= 32'h0;
            blink_ph_q  <= ~blink_ph_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // ==========================================================
    // indicator selection
    always_comb begin
        link_on   = link_good;
        actcol_on = active;
        case (led_mode)
            PLSL_MODE_2: begin
                link_on   = link_good & ~(active & blink_ph_q);
                actcol_on = collision;
            end
            PLSL_MODE_3: begin
                link_on   = link_good & ~(active & blink_ph_q);
                actcol_on = dup_sel ? full_duplex : collision;
            end
            default: begin
                link_on   = link_good;
                actcol_on = active;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link_led_q   <= ACTIVE_LOW;
            speed_led_q  <= ACTIVE_LOW;
            actcol_led_q <= ACTIVE_LOW;
        end else begin
            link_led_q   <= link_on ^ ACTIVE_LOW;
            speed_led_q  <= speed_100 ^ ACTIVE_LOW;
            actcol_led_q <= actcol_on ^ ACTIVE_LOW;
        end
    end
endmodule

// File: tb/plsl_top_assertions.sv
// plsl_top_assertions: port-level checker for plsl_top, bound below
// assumes the single clk_sys domain and async active-low reset_n
`timescale 1ns/10ps
`include "plsl_map.svh"
module plsl_top_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        irq,
    // clock output and status
    input wire logic        system_clock_output,
    input wire logic        speed_100,
    input wire logic        speed_indicator_o,
    input wire logic        speed_indicator_oe,
    // shared pin
    input wire logic        powerdown_irq_pin_i,
    input wire logic        powerdown_irq_pin_o,
    input wire logic        powerdown_irq_pin_oe,
    input wire logic        power_down,
    // straps
    input wire logic        rmii_strap,
    input wire logic        phy_addr_strap_bit0,
    input wire logic [3:0]  phy_addr_strap_upper,
    input wire logic [4:0]  phy_addr_pull_up,
    input wire logic        straps_released,
    input wire logic        mii_isolate,
    input wire logic        rmii_mode
);
    parameter int unsigned BLINK_HALF_CYCLES = 4;
    parameter bit          LED_ACTIVE_LOW    = 1'b1;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // assertions
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("stray read data");
    unmapped_read_a: assert property (reg_rd && reg_addr > 8'h10 |=> reg_rdata == 16'h0000)
        else $error("unmapped read data");
    rmii_clock_a: assert property (rmii_mode && $rose(system_clock_output) |=> !system_clock_output)
        else $error("rmii clock wrong");
    mii_clock_a: assert property (!rmii_mode && $rose(system_clock_output) |=> system_clock_output ##1 !system_clock_output)
        else $error("mii clock wrong");
    clock_runs_a: assert property (straps_released && !system_clock_output |-> ##[1:2] system_clock_output)
        else $error("clock stalled");
    speed_led_a: assert property (speed_indicator_oe && $past(speed_indicator_oe)
        |-> speed_indicator_o == ($past(speed_100, 2) ^ LED_ACTIVE_LOW))
        else $error("speed led wrong");
    pin_drain_a: assert property (powerdown_irq_pin_oe |-> !powerdown_irq_pin_o && irq)
        else $error("pin pulled without irq");
    pdown_pin_a: assert property (power_down |-> !$past(powerdown_irq_pin_i))
        else $error("stray power down");
    pull_level_a: assert property (phy_addr_pull_up == `PLSL_ADDR_PULL)
        else $error("pull pattern wrong");
    release_time_a: assert property ($rose(reset_n) |-> !straps_released [*2] ##1 straps_released)
        else $error("release time wrong");
    strap_iso_a: assert property ($rose(reset_n)
        |=> mii_isolate == ({$past(phy_addr_strap_upper), $past(phy_addr_strap_bit0)} == 5'h00))
        else $error("isolate not strapped");
    strap_rmii_a: assert property ($rose(reset_n) |=> rmii_mode == $past(rmii_strap))
        else $error("rmii not strapped");
    iso_hold_a: assert property (straps_released && $past(straps_released) |-> $stable(mii_isolate))
        else $error("isolate changed");
endmodule

bind plsl_top plsl_top_checker #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES), .LED_ACTIVE_LOW(LED_ACTIVE_LOW)) chk_u (.*);

// File: tb/plsl_board.sv
// plsl_board: strap resistors, pulls, shared pin pull-up, leds, reference
// assumes strap settings change only between resets, ext_pdown at any time
`timescale 1ns/10ps
module plsl_board (
    // clock
    input  wire logic       clk_sys,
    // board settings
    input  wire logic [4:0] strap_drv,
    input  wire logic [4:0] strap_val,
    input  wire logic       rmii_val,
    input  wire logic       ext_pdown,
    // device side
    input  wire logic [4:0] phy_addr_pull_up,
    input  wire logic       straps_released,
    input  wire logic       pin_o,
    input  wire logic       pin_oe,
    input  wire logic [2:0] led_o,
    input  wire logic [2:0] led_oe,
    output logic            rmii_strap,
    output logic            phy_addr_strap_bit0,
    output logic [3:0]      phy_addr_strap_upper,
    output logic            ref_clock_input,
    output logic            powerdown_irq_pin_i,
    output logic [2:0]      led_lit
);
    logic [4:0] noise_q = 5'h00;
    logic [4:0] strap_lvl;
    logic       ref_q = 1'b0;
    // ==========================================================
    // straps: resistor, else weak pull; after release pins change
    always_comb strap_lvl = straps_released ? noise_q
                                            : (strap_drv & strap_val) | (~strap_drv & phy_addr_pull_up);
    always @(posedge clk_sys) noise_q <= ~strap_lvl;
    always @(posedge clk_sys) ref_q <= ~ref_q;
    assign phy_addr_strap_bit0  = strap_lvl[0];
    assign phy_addr_strap_upper = strap_lvl[4:1];
    assign rmii_strap           = straps_released ? noise_q[0] : rmii_val;
    assign ref_clock_input      = ref_q;
    // ==========================================================
    // open-drain pin with pull-up; leds lit when driven low
    assign powerdown_irq_pin_i = !(pin_oe && !pin_o) && !ext_pdown;
    assign led_lit             = led_oe & ~led_o;
endmodule

// File: tb/plsl_top_tb.sv
// plsl_top_tb: register-level tests of the sideband logic
// assumes plsl_board as far side and the bound checker
`timescale 1ns/10ps
`include "plsl_map.svh"
module plsl_top_tb;
    logic        clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic        irq, ref_clock_input, crystal_drive_output, system_clock_output;
    logic        link_good = 0, speed_100 = 0, tx_active = 0, rx_active = 0, collision = 0, full_duplex = 0;
    logic [2:0]  led_o, led_oe, led_lit;
    logic        pin_i, pin_o, pin_oe, power_down, rmii_strap, strap_b0, straps_released, mii_isolate, rmii_mode;
    logic [3:0]  strap_up;
    logic [4:0]  pull_up, strap_drv = 5'h00, strap_val = 5'h00;
    logic        rmii_val = 0, ext_pdown = 0;
    int          errors = 0, num_checks = 0, cyc = 0, n;
    always #5 clk_sys = ~clk_sys;
    plsl_top #(.BLINK_HALF_CYCLES(4), .LED_ACTIVE_LOW(1'b1)) dut_u (.*,
        .link_indicator_o(led_o[0]), .link_indicator_oe(led_oe[0]), .speed_indicator_o(led_o[1]),
        .speed_indicator_oe(led_oe[1]), .activity_collision_indicator_o(led_o[2]),
        .activity_collision_indicator_oe(led_oe[2]), .powerdown_irq_pin_i(pin_i), .powerdown_irq_pin_o(pin_o),
        .powerdown_irq_pin_oe(pin_oe), .phy_addr_strap_bit0(strap_b0), .phy_addr_strap_upper(strap_up),
        .phy_addr_pull_up(pull_up));
    plsl_board board_u (.*, .phy_addr_pull_up(pull_up), .phy_addr_strap_bit0(strap_b0),
        .phy_addr_strap_upper(strap_up), .powerdown_irq_pin_i(pin_i));
    // ==========================================================
    // tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic do_reset(input logic [4:0] drv, input logic [4:0] val, input logic rm);
        @(posedge clk_sys);
        strap_drv <= drv; strap_val <= val; rmii_val <= rm; reset_n <= 1'b0;
        repeat (`PLSL_RST_MIN_CYC) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic count_toggles(output int t);
        logic last;
        t = 0;
        wait_cyc(1);
        last = system_clock_output;
        repeat (20) begin
            wait_cyc(1);
            if (system_clock_output !== last) t++;
            last = system_clock_output;
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // ==========================================================
    // tests
    initial begin
        do_reset(5'h00, 5'h00, 1'b0);
        rd(`PLSL_OFS_PHY_CONTROL_REGISTER, 16'h0001);
        chk(mii_isolate, 0);
        chk(straps_released, 1);
        count_toggles(n);
        chk(n, 10);
        chk(crystal_drive_output, ref_clock_input);
        rd(`PLSL_OFS_STAT, 16'h1900);
        do_reset(5'h1f, 5'h00, 1'b1);
        rd(`PLSL_OFS_PHY_CONTROL_REGISTER, 16'h0020);
        chk(mii_isolate, 1);
        count_toggles(n);
        chk(n, 20);
        chk(crystal_drive_output, 0);
        rd(`PLSL_OFS_STAT, 16'h3205);
        do_reset(5'h1f, 5'h1f, 1'b0);
        rd(`PLSL_OFS_PHY_CONTROL_REGISTER, 16'h001f);
        wr(`PLSL_OFS_PHY_CONTROL_REGISTER, 16'h0000);
        rd(`PLSL_OFS_PHY_CONTROL_REGISTER, 16'h0000);
        chk(mii_isolate, 0);
        wr(`PLSL_OFS_IRQ_MASK, 16'h0001);
        wr(`PLSL_OFS_CTRL, 16'h0003);
        do_reset(5'h1f, 5'h1f, 1'b0);
        rd(`PLSL_OFS_IRQ_MASK, 16'h0000);
        rd(`PLSL_OFS_CTRL, 16'h0001);
        rd(`PLSL_OFS_PHY_CONTROL_REGISTER, 16'h001f);
        rd(8'h14, 16'h0000);
        // interrupt through the shared pin
        wr(`PLSL_OFS_IRQ_MASK, 16'h0001);
        link_good <= 1'b1;
        wait_cyc(2);
        chk(irq, 1);
        chk(pin_i, 1);
        wr(`PLSL_OFS_CTRL, 16'h0009);
        wait_cyc(1);
        chk(pin_i, 0);
        rd(`PLSL_OFS_IRQ_STAT, 16'h0001);
        wait_cyc(1);
        chk({irq, pin_i}, 2'b01);
        collision <= 1'b1;
        wait_cyc(2);
        chk(irq, 0);
        rd(`PLSL_OFS_IRQ_STAT, 16'h0004);
        collision <= 1'b0;
        wr(`PLSL_OFS_CTRL, 16'h0001);
        ext_pdown <= 1'b1;
        wait_cyc(3);
        chk(power_down, 1);
        ext_pdown <= 1'b0;
        wait_cyc(3);
        chk(power_down, 0);
        // indicators; lit bits are {actcol, speed, link}
        speed_100 <= 1'b1;
        wait_cyc(3);
        chk(led_lit, 3'b011);
        tx_active <= 1'b1;
        wait_cyc(3);
        chk(led_lit, 3'b111);
        tx_active <= 1'b0;
        link_good <= 1'b0;
        speed_100 <= 1'b0;
        wait_cyc(3);
        chk(led_lit, 3'b000);
        wr(`PLSL_OFS_CTRL, 16'h0002);
        link_good <= 1'b1;
        collision <= 1'b1;
        wait_cyc(3);
        chk(led_lit, 3'b101);
        rx_active <= 1'b1;
        n = 0;
        repeat (16) begin
            wait_cyc(1);
            if (led_lit[0] === 1'b1) n++;
        end
        chk(n > 0 && n < 16, 1);
        rx_active <= 1'b0;
        collision <= 1'b0;
        wr(`PLSL_OFS_CTRL, 16'h0007);
        full_duplex <= 1'b1;
        wait_cyc(3);
        chk(led_lit, 3'b101);
        wr(`PLSL_OFS_CTRL, 16'h0003);
        wait_cyc(3);
        chk(led_lit, 3'b001);
        print_verdict();
    end
endmodule
